// [rtl/storage_key_protection.sv]
// Storage guard: per-block key and read-only tables, access check, word check code.
// Assumes requesters and the storage array share ref_clk; storage answers a read
// with mem_rvalid some cycles after mem_en, one answer per read, in order.
//
// Functional notes
// - Storage is split into 2048-byte blocks, each with its own key.
// - Writes and fetches pass only when user key equals the block key.
// - Key check applies to every program level and every cycle-stealing adapter.
// - Each block has a read-only bit; writes to read-only blocks are refused.
// - Every read is checked; single errors corrected, double errors flagged.
// - Capacity 512 KB to 2 MB in 256 KB steps; tables sized for the full 2 MB.
// - Five interrupt levels are separate users, each presenting its own key.
`default_nettype none

module storage_key_protection (
  input  wire logic                                              ref_clk,
  input  wire logic                                              sys_rst,
  input  wire logic [storage_key_protection_pkg::UNITS_W-1:0]    installed_units,
  input  wire logic [storage_key_protection_pkg::N_LEVELS-1:0][storage_key_protection_pkg::KEY_W-1:0] level_keys,
  input  wire logic [storage_key_protection_pkg::KEY_W-1:0]      cycle_steal_key,
  input  wire logic                                              key_set_valid,
  input  wire logic [storage_key_protection_pkg::BLK_W-1:0]      key_set_block,
  input  wire logic [storage_key_protection_pkg::KEY_W-1:0]      key_set_key,
  input  wire logic                                              key_set_read_only,
  input  wire logic                                              req_valid,
  input  wire storage_key_protection_pkg::access_kind_t          req_kind,
  input  wire logic [storage_key_protection_pkg::USER_W-1:0]     req_user,
  input  wire logic [storage_key_protection_pkg::ADDR_W-1:0]     req_addr,
  input  wire logic [storage_key_protection_pkg::DATA_W-1:0]     req_wdata,
  output logic                                                   mem_en,
  output logic                                                   mem_we,
  output logic [storage_key_protection_pkg::WADDR_W-1:0]         mem_addr,
  output logic [storage_key_protection_pkg::CW_W-1:0]            mem_wdata,
  input  wire logic                                              mem_rvalid,
  input  wire logic [storage_key_protection_pkg::CW_W-1:0]       mem_rdata,
  output logic                                                   rsp_valid,
  output logic [storage_key_protection_pkg::DATA_W-1:0]          rsp_rdata,
  output logic                                                   rsp_corrected,
  output logic                                                   rsp_uncorrectable,
  output logic                                                   viol_valid,
  output logic [storage_key_protection_pkg::USER_W-1:0]          viol_user
);

  // ----------------------------------------------------------------------------
  // Protection tables
  // ----------------------------------------------------------------------------
  logic [storage_key_protection_pkg::KEY_W-1:0] key_ram      [storage_key_protection_pkg::N_BLOCKS];
  logic [storage_key_protection_pkg::KEY_W-1:0] next_key_ram [storage_key_protection_pkg::N_BLOCKS];
  logic [storage_key_protection_pkg::N_BLOCKS-1:0] ro_bits;
  logic [storage_key_protection_pkg::N_BLOCKS-1:0] next_ro_bits;

  logic [storage_key_protection_pkg::UNITS_W-1:0] units_c;
  logic [storage_key_protection_pkg::CAP_W-1:0]   cap_blocks;

  // Out-of-range straps are clamped to the supported span.
  always_comb begin
    if (installed_units < storage_key_protection_pkg::MIN_UNITS) begin
      units_c = storage_key_protection_pkg::MIN_UNITS;
    end else if (installed_units > storage_key_protection_pkg::MAX_UNITS) begin
      units_c = storage_key_protection_pkg::MAX_UNITS;
    end else begin
      units_c = installed_units;
    end
    cap_blocks = storage_key_protection_pkg::CAP_W'(units_c)
                 << storage_key_protection_pkg::UNIT_BLK_SHIFT;
  end

  logic set_in_range;
  assign set_in_range = {1'b0, key_set_block} < cap_blocks;

  always_comb begin
    next_key_ram = key_ram;
    next_ro_bits = ro_bits;
    if (key_set_valid && set_in_range) begin
      next_key_ram[key_set_block] = key_set_key;
      next_ro_bits[key_set_block] = key_set_read_only;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < storage_key_protection_pkg::N_BLOCKS; i++) begin
        key_ram[i] <= storage_key_protection_pkg::KEY_RESET;
      end
      ro_bits <= '0;
    end else begin
      key_ram <= next_key_ram;
      ro_bits <= next_ro_bits;
    end
  end

  // ----------------------------------------------------------------------------
  // Access check
  // ----------------------------------------------------------------------------
  logic [storage_key_protection_pkg::BLK_W-1:0] req_block;
  logic [storage_key_protection_pkg::KEY_W-1:0] user_key;
  logic                                         user_known;
  logic                                         in_range;
  logic                                         key_ok;
  logic                                         ro_ok;
  logic                                         grant;
  logic                                         refuse;

  assign req_block = req_addr[storage_key_protection_pkg::ADDR_W-1:
                              storage_key_protection_pkg::BLOCK_SHIFT];

  always_comb begin
    user_key   = cycle_steal_key;
    user_known = 1'b1;
    if (req_user == storage_key_protection_pkg::USER_CYCLE_STEAL) begin
      user_key = cycle_steal_key;
    end else if (int'(req_user) < storage_key_protection_pkg::N_LEVELS) begin
      user_key = level_keys[req_user];
    end else begin
      user_known = 1'b0;
    end
  end

  always_comb begin
    in_range = {1'b0, req_block} < cap_blocks;
    key_ok   = (req_kind == storage_key_protection_pkg::ACC_READ)
               || (user_known && (user_key == key_ram[req_block]));
    ro_ok    = !((req_kind == storage_key_protection_pkg::ACC_WRITE)
                 && ro_bits[req_block]);
    grant    = req_valid && in_range && key_ok && ro_ok;
    refuse   = req_valid && !grant;
  end

  // ----------------------------------------------------------------------------
  // Storage request and violation report
  // ----------------------------------------------------------------------------
  logic                                           next_mem_en;
  logic                                           next_mem_we;
  logic [storage_key_protection_pkg::WADDR_W-1:0] next_mem_addr;
  logic [storage_key_protection_pkg::CW_W-1:0]    next_mem_wdata;
  logic                                           next_viol_valid;
  logic [storage_key_protection_pkg::USER_W-1:0]  next_viol_user;

  always_comb begin
    next_mem_en     = grant;
    next_mem_we     = grant && (req_kind == storage_key_protection_pkg::ACC_WRITE);
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    next_viol_valid = refuse;
    next_viol_user  = viol_user;
    if (grant) begin
      next_mem_addr  = req_addr[storage_key_protection_pkg::ADDR_W-1:
                                storage_key_protection_pkg::WORD_SHIFT];
      next_mem_wdata = storage_key_protection_pkg::ecc_encode(req_wdata);
    end
    if (refuse) begin
      next_viol_user = req_user;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_en     <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= '0;
      mem_wdata  <= '0;
      viol_valid <= 1'b0;
      viol_user  <= '0;
    end else begin
      mem_en     <= next_mem_en;
      mem_we     <= next_mem_we;
      mem_addr   <= next_mem_addr;
      mem_wdata  <= next_mem_wdata;
      viol_valid <= next_viol_valid;
      viol_user  <= next_viol_user;
    end
  end

  // ----------------------------------------------------------------------------
  // Read check and correction
  // ----------------------------------------------------------------------------
  storage_key_protection_pkg::ecc_result_t dec;
  logic                                          next_rsp_valid;
  logic [storage_key_protection_pkg::DATA_W-1:0] next_rsp_rdata;
  logic                                          next_rsp_corrected;
  logic                                          next_rsp_uncorrectable;

  assign dec = storage_key_protection_pkg::ecc_decode(mem_rdata);

  always_comb begin
    next_rsp_valid         = mem_rvalid;
    next_rsp_rdata         = rsp_rdata;
    next_rsp_corrected     = 1'b0;
    next_rsp_uncorrectable = 1'b0;
    if (mem_rvalid) begin
      next_rsp_rdata         = dec.data;
      next_rsp_corrected     = dec.single;
      next_rsp_uncorrectable = dec.double;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_valid         <= 1'b0;
      rsp_rdata         <= '0;
      rsp_corrected     <= 1'b0;
      rsp_uncorrectable <= 1'b0;
    end else begin
      rsp_valid         <= next_rsp_valid;
      rsp_rdata         <= next_rsp_rdata;
      rsp_corrected     <= next_rsp_corrected;
      rsp_uncorrectable <= next_rsp_uncorrectable;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_guarded_req;
    req_valid && (req_kind != storage_key_protection_pkg::ACC_READ) && in_range;
  endsequence

  sequence s_refused_out;
    viol_valid && !mem_en && !mem_we;
  endsequence

  property p_block_key_select;
    @(posedge ref_clk) disable iff (sys_rst)
    (key_set_valid && set_in_range) |=> (key_ram[$past(key_set_block)] == $past(key_set_key));
  endproperty
  a_block_key_select: assert property (p_block_key_select) else $error("block key not stored");

  property p_key_mismatch;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_guarded_req and (user_known && (user_key != key_ram[req_block]))) |=> s_refused_out;
  endproperty
  a_key_mismatch: assert property (p_key_mismatch) else $error("mismatched key not refused");

  property p_fetch_match;
    @(posedge ref_clk) disable iff (sys_rst)
    (req_valid && (req_kind == storage_key_protection_pkg::ACC_FETCH) && in_range
     && user_known && (user_key == key_ram[req_block])) |=> (mem_en && !mem_we && !viol_valid);
  endproperty
  a_fetch_match: assert property (p_fetch_match) else $error("matching fetch not passed");

  property p_adapter_checked;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_guarded_req and (req_user == storage_key_protection_pkg::USER_CYCLE_STEAL)
     and (cycle_steal_key != key_ram[req_block]))
    |=> (s_refused_out and (viol_user == storage_key_protection_pkg::USER_CYCLE_STEAL));
  endproperty
  a_adapter_checked: assert property (p_adapter_checked) else $error("adapter bypassed key check");

  property p_read_only;
    @(posedge ref_clk) disable iff (sys_rst)
    (req_valid && (req_kind == storage_key_protection_pkg::ACC_WRITE) && ro_bits[req_block])
    |=> s_refused_out;
  endproperty
  a_read_only: assert property (p_read_only) else $error("write to read-only block passed");

  property p_single_fix;
    @(posedge ref_clk) disable iff (sys_rst)
    (mem_rvalid && dec.single) |=> (rsp_valid && rsp_corrected && !rsp_uncorrectable
                                    && (rsp_rdata == $past(dec.data)));
  endproperty
  a_single_fix: assert property (p_single_fix) else $error("single error not corrected");

  property p_double_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    (mem_rvalid && dec.double) |=> (rsp_valid && rsp_uncorrectable && !rsp_corrected);
  endproperty
  a_double_flag: assert property (p_double_flag) else $error("double error not flagged");

  property p_capacity;
    @(posedge ref_clk) disable iff (sys_rst)
    (req_valid && !in_range) |=> s_refused_out;
  endproperty
  a_capacity: assert property (p_capacity) else $error("access beyond capacity passed");

  property p_level_key;
    @(posedge ref_clk) disable iff (sys_rst)
    (req_valid && (req_kind == storage_key_protection_pkg::ACC_WRITE) && in_range
     && !ro_bits[req_block] && (int'(req_user) < storage_key_protection_pkg::N_LEVELS)
     && (level_keys[req_user] == key_ram[req_block])) |=> (mem_en && mem_we);
  endproperty
  a_level_key: assert property (p_level_key) else $error("level key write not passed");

  property p_viol_user;
    @(posedge ref_clk) disable iff (sys_rst)
    refuse |=> (s_refused_out and (viol_user == $past(req_user)));
  endproperty
  a_viol_user: assert property (p_viol_user) else $error("violation report wrong");

endmodule // storage_key_protection

`default_nettype wire

// [rtl/storage_key_protection_pkg.sv]
// Constants, types and check-code functions for the storage key protection block.
// Assumes a single 20 MHz clock domain shared by all requesters and the storage array.
`default_nettype none

package storage_key_protection_pkg;

  // ----------------------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------------------
  localparam int ADDR_W          = 21;
  localparam int BLOCK_BYTES     = 2048;
  localparam int BLOCK_SHIFT     = $clog2(BLOCK_BYTES);
  localparam int BLK_W           = ADDR_W - BLOCK_SHIFT;
  localparam int N_BLOCKS        = 1 << BLK_W;
  localparam int UNIT_KBYTES     = 256;
  localparam int UNIT_BLK_SHIFT  = $clog2(UNIT_KBYTES * 1024 / BLOCK_BYTES);
  localparam int UNITS_W         = 4;
  localparam logic [UNITS_W-1:0] MIN_UNITS = 4'h2;
  localparam logic [UNITS_W-1:0] MAX_UNITS = 4'h8;
  localparam int CAP_W           = BLK_W + 1;
  localparam int WORD_SHIFT      = 2;
  localparam int WADDR_W         = ADDR_W - WORD_SHIFT;

  // ----------------------------------------------------------------------------
  // Keys and users
  // ----------------------------------------------------------------------------
  localparam int KEY_W           = 4;
  localparam int N_LEVELS        = 5;
  localparam int USER_W          = 3;
  localparam logic [USER_W-1:0] USER_CYCLE_STEAL = 3'h5;
  localparam logic [KEY_W-1:0]  KEY_RESET        = 4'h0;

  typedef enum logic [1:0] {
    ACC_READ  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_FETCH = 2'b10
  } access_kind_t;

  // ----------------------------------------------------------------------------
  // Single-error-correct, double-error-detect word code
  // ----------------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int SYN_W  = 6;
  localparam int CW_W   = DATA_W + SYN_W + 1;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              single;
    logic              double;
  } ecc_result_t;

  // Bit 0 is overall parity; check bits sit at the power-of-two positions.
  function automatic logic [CW_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [CW_W-1:0] cw;
    logic            par;
    int              k;
    cw = '0;
    k  = 0;
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i] = d[k];
        k++;
      end
    end
    for (int p = 0; p < SYN_W; p++) begin
      par = 1'b0;
      for (int i = 1; i < CW_W; i++) begin
        if ((((i >> p) & 1) == 1) && (i != (1 << p))) begin
          par = par ^ cw[i];
        end
      end
      cw[1 << p] = par;
    end
    cw[0] = ^cw[CW_W-1:1];
    return cw;
  endfunction

  function automatic ecc_result_t ecc_decode(input logic [CW_W-1:0] cw);
    ecc_result_t     r;
    logic [SYN_W-1:0] syn;
    logic [CW_W-1:0] fixed;
    int              k;
    r   = '0;
    syn = '0;
    k   = 0;
    for (int p = 0; p < SYN_W; p++) begin
      for (int i = 1; i < CW_W; i++) begin
        if (((i >> p) & 1) == 1) begin
          syn[p] = syn[p] ^ cw[i];
        end
      end
    end
    fixed = cw;
    if (^cw) begin
      if (int'(syn) < CW_W) begin
        fixed[syn] = ~fixed[syn];
        r.single   = 1'b1;
      end else begin
        r.double = 1'b1;
      end
    end else if (syn != '0) begin
      r.double = 1'b1;
    end
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        r.data[k] = fixed[i];
        k++;
      end
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// [dv/storage_array_model.sv]
// Behavioural storage array facing the guard's storage port.
// Assumes the guard's clock; reads are answered in order after 1 or 3 cycles.
`default_nettype none

module storage_array_model (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic [38:0] flip_mask,
  input  wire logic        mem_en,
  input  wire logic        mem_we,
  input  wire logic [18:0] mem_addr,
  input  wire logic [38:0] mem_wdata,
  output logic             mem_rvalid,
  output logic [38:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [38:0] cells [int];
  logic [38:0] pend_cw [$];
  int          pend_due [$];
  int          cyc;

  initial begin
    cyc        = 0;
    mem_rvalid = 1'b0;
    mem_rdata  = 39'h00_0000_0000;
  end

  // Idle read data inverts every idle cycle, alternating between the last word and its inverse.
  always @(posedge ref_clk) begin
    cyc++;
    if (mem_en === 1'b1 && mem_we === 1'b1) begin
      cells[int'(mem_addr)] = mem_wdata;
    end else if (mem_en === 1'b1) begin
      pend_cw.push_back(cells.exists(int'(mem_addr)) ? cells[int'(mem_addr)] : '0);
      pend_due.push_back(cyc + (slow ? 3 : 1));
    end
    if (pend_due.size() > 0 && pend_due[0] <= cyc) begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= pend_cw.pop_front() ^ flip_mask;
      void'(pend_due.pop_front());
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
    end
  end
endmodule // storage_array_model

`default_nettype wire

// [dv/storage_key_protection_tb_top.sv]
// Self-checking bench for the storage key protection block.
// Assumes storage_array_model on the storage port and one 20 MHz clock.
`default_nettype none

module storage_key_protection_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int due; logic viol; logic [2:0] user; logic we; logic [18:0] waddr;}
    grant_note_t;
  typedef struct {logic [31:0] data; logic corr; logic unc;} read_note_t;

  logic            ref_clk, sys_rst, slow, key_set_valid, key_set_read_only, req_valid;
  logic [3:0]      installed_units, cycle_steal_key, key_set_key;
  logic [4:0][3:0] level_keys;
  logic [9:0]      key_set_block;
  logic [2:0]      req_user, viol_user;
  logic [20:0]     req_addr;
  logic [31:0]     req_wdata, rsp_rdata;
  logic [38:0]     flip_mask, mem_wdata, mem_rdata;
  logic [18:0]     mem_addr;
  logic            mem_en, mem_we, mem_rvalid, rsp_valid, rsp_corrected, rsp_uncorrectable;
  logic            viol_valid;
  logic [3:0]      key_tbl [1024];
  logic            ro_tbl [1024];
  logic [31:0]     shadow [int];
  logic [3:0]      unit_tab [5] = '{4'h1, 4'h2, 4'h5, 4'h8, 4'hf};
  grant_note_t     notes [$];
  read_note_t      reads [$];
  grant_note_t     gn;
  read_note_t      rn;
  int              seed = 32'h0000_e560;
  int              cyc, failures, compares;
  storage_key_protection_pkg::access_kind_t req_kind;

  storage_key_protection i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .installed_units(installed_units), .level_keys(level_keys),
    .cycle_steal_key(cycle_steal_key), .key_set_valid(key_set_valid),
    .key_set_block(key_set_block), .key_set_key(key_set_key),
    .key_set_read_only(key_set_read_only), .req_valid(req_valid), .req_kind(req_kind),
    .req_user(req_user), .req_addr(req_addr), .req_wdata(req_wdata), .mem_en(mem_en),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_corrected(rsp_corrected), .rsp_uncorrectable(rsp_uncorrectable),
    .viol_valid(viol_valid), .viol_user(viol_user));

  storage_array_model i_mem (.ref_clk(ref_clk), .slow(slow), .flip_mask(flip_mask),
    .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc++;

  // ---------------------------------------------------------------------------
  // Reporting and drivers
  // ---------------------------------------------------------------------------
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] seen);
    compares++;
    if (exp !== seen) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic int capacity();
    int u;
    u = installed_units < 2 ? 2 : (installed_units > 8 ? 8 : int'(installed_units));
    return u * 128;
  endfunction

  task automatic idle();
    req_valid = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic set_key(input logic [9:0] blk, input logic [3:0] key, input logic ro);
    req_valid         = 1'b0;
    key_set_valid     = 1'b1;
    key_set_block     = blk;
    key_set_key       = key;
    key_set_read_only = ro;
    if (blk < capacity()) begin
      key_tbl[blk] = key;
      ro_tbl[blk]  = ro;
    end
    @(negedge ref_clk);
    key_set_valid = 1'b0;
  endtask

  // Notes the expected outcome, then presents the request for one edge.
  task automatic request(input logic [1:0] kind, input logic [2:0] user,
                         input logic [20:0] addr, input logic [31:0] wdata);
    logic [9:0] blk;
    logic [3:0] ukey;
    logic       refuse;
    blk    = addr[20:11];
    ukey   = (user < 5) ? level_keys[user] : cycle_steal_key;
    refuse = blk >= capacity();
    if (kind != 2'b00) refuse |= (user > 5) || (ukey != key_tbl[blk]);
    if (kind == 2'b01) refuse |= ro_tbl[blk];
    notes.push_back('{cyc + 1, refuse, user, kind == 2'b01, addr[20:2]});
    if (!refuse && kind == 2'b01) shadow[int'(addr[20:2])] = wdata;
    if (!refuse && kind != 2'b01) begin
      reads.push_back('{shadow.exists(int'(addr[20:2])) ? shadow[int'(addr[20:2])] : 0,
                       $countones(flip_mask) == 1, $countones(flip_mask) > 1});
    end
    req_valid = 1'b1;
    req_kind  = storage_key_protection_pkg::access_kind_t'(kind);
    req_user  = user;
    req_addr  = addr;
    req_wdata = wdata;
    @(negedge ref_clk);
  endtask

  task automatic drain();
    req_valid = 1'b0;
    for (int i = 0; i < 40 && notes.size() + reads.size() > 0; i++) @(negedge ref_clk);
    if (notes.size() + reads.size() > 0) begin
      failures++;
      $display("[FAIL] pending answers expected 0 seen %0d", notes.size() + reads.size());
      complete_run();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Output monitor
  // ---------------------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (mem_en === 1'b1 || viol_valid === 1'b1) begin
      if (notes.size() == 0) check("spare answer", 0, 1);
      else begin
        gn = notes.pop_front();
        check("answer cycle", gn.due, cyc);
        check("viol_valid", gn.viol, viol_valid);
        check("mem_en", !gn.viol, mem_en);
        if (gn.viol) check("viol_user", gn.user, viol_user);
        else check("mem_we mem_addr", {gn.we, gn.waddr}, {mem_we, mem_addr});
        if (!gn.viol && gn.we) check("write parity", 0, ^mem_wdata);
      end
    end else if (notes.size() > 0 && notes[0].due <= cyc) begin
      gn = notes.pop_front();
      check("missing answer", gn.due, 0);
    end
    if (rsp_valid === 1'b1) begin
      if (reads.size() == 0) check("spare read answer", 0, 1);
      else begin
        rn = reads.pop_front();
        check("rsp_rdata", rn.data, rsp_rdata);
        check("rsp flags", {rn.corr, rn.unc}, {rsp_corrected, rsp_uncorrectable});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("[FAIL] run length expected 20000 seen more");
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    cyc = 0;
    failures = 0;
    compares = 0;
    sys_rst = 1'b1;
    slow = 1'b0;
    flip_mask = '0;
    installed_units = 4'h8;
    level_keys = '0;
    cycle_steal_key = 4'h0;
    key_set_valid = 1'b0;
    key_set_block = '0;
    key_set_key = 4'h0;
    key_set_read_only = 1'b0;
    req_valid = 1'b0;
    req_kind = storage_key_protection_pkg::ACC_READ;
    req_user = '0;
    req_addr = '0;
    req_wdata = '0;
    foreach (key_tbl[i]) begin
      key_tbl[i] = 4'h0;
      ro_tbl[i]  = 1'b0;
    end
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 32; i++) begin
      request(2'b01, 3'(i % 6), {10'(i / 4), 11'h000} | 21'(4 * (i % 4)), $random(seed));
    end
    request(2'b01, 3'h6, 21'h00_0000, $random(seed));
    request(2'b10, 3'h7, 21'h00_0004, 0);
    request(2'b00, 3'h6, 21'h00_0000, 0);
    request(2'b11, 3'h7, 21'h00_0008, 0);
    idle();
    level_keys = {4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
    cycle_steal_key = 4'h6;
    for (int k = 1; k < 7; k++) begin
      set_key(10'h003, 4'(k), 1'b0);
      for (int u = 0; u < 8; u++) begin
        request(2'b01, 3'(u), 21'h00_1804, $random(seed));
        request(2'b10, 3'(u), 21'h00_1808, 0);
      end
    end
    set_key(10'h004, 4'h1, 1'b1);
    request(2'b01, 3'h0, 21'h00_2000, $random(seed));
    request(2'b10, 3'h0, 21'h00_2000, 0);
    request(2'b00, 3'h6, 21'h00_2004, 0);
    set_key(10'h004, 4'h1, 1'b0);
    request(2'b01, 3'h0, 21'h00_2000, $random(seed));
    request(2'b00, 3'h1, 21'h00_2000, 0);
    for (int k = 0; k < 5; k++) begin
      idle();
      installed_units = unit_tab[k];
      if (k < 2) set_key(10'h12c, 4'h1, 1'b0);
      request(2'b00, 3'h0, {10'(capacity() - 1), 11'h7fc}, 0);
      request(2'b00, 3'h0, {10'(capacity()), 11'h000}, 0);
    end
    request(2'b01, 3'h0, {10'h12c, 11'h000}, $random(seed));
    for (int k = 0; k < 3; k++) begin
      drain();
      slow = k != 0;
      flip_mask = (k == 0) ? '0 : 39'h00_0000_0001 << ($unsigned($random(seed)) % 39);
      // One flip on a check position, one on the overall parity bit, so the data field stays intact.
      if (k == 2) begin
        flip_mask = (39'h00_0000_0001 << (1 << ($unsigned($random(seed)) % 5)))
                    | 39'h00_0000_0001;
      end
      for (int w = 0; w < 4; w++) request(2'b00, 3'h5, 21'(4 * w), 0);
    end
    drain();
    flip_mask = '0;
    for (int k = 0; k < 300; k++) begin
      if (k % 25 == 0) begin
        slow = 1'($random(seed));
        set_key(10'($unsigned($random(seed)) % 8), 4'(1 + $unsigned($random(seed)) % 6),
                1'($random(seed)));
      end
      request(2'($random(seed)), 3'($random(seed)),
              {10'($unsigned($random(seed)) % 8), 11'($random(seed))}, $random(seed));
    end
    drain();
    complete_run();
  end
endmodule // storage_key_protection_tb_top

`default_nettype wire
